// >>> src/system_clock_distribution.sv
`timescale 1ns/1ps
// Functional notes
// - Primary clock is the host clock input in host mode and the bus clock input in agent mode.
// - In host mode the divide pin picks undivided or halved primary clock for the sync output.
// - Each bus clock output is driven only while its own enable bit is set.
// - System and core multipliers come from the reset configuration word caught at reset.
// - The core clock is the system bus clock multiplied by the core multiplier setting.
// - Memory clock is system clock times one plus the memory mode bit, halved for the pair.
// - Local bus interface clock is one or two times the system clock by its mode bit.
// - Local bus clock outputs run at a half, quarter or eighth of the interface clock.
// - Unit clocks default to third rate (pci/dma to full) and offer off, full, half, third; pci/dma only off or full.
// - Unit ratios change only by register write after reset; second two-wire clock is fixed.
// - In host mode the primary clock runs at sync input times one plus the divide value.
// - The system pll vco runs at double scale when either clock-mode bit is set.
module system_clock_distribution #(
	parameter int BUS_CLOCK_OUTS = 5
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic pci_host_mode,
	input wire logic host_primary_clock_in,
	input wire logic bus_clock_in,
	input wire logic sync_clock_in,
	input wire logic input_divide_select,
	input wire logic [clock_dist_pkg::RCW_WIDTH-1:0] reset_config_word_low,
	input wire logic [BUS_CLOCK_OUTS-1:0] output_clock_control,
	input wire logic system_clock_control_write,
	input wire logic [11:0] system_clock_control_wdata,
	input wire logic local_bus_clock_ratio_write,
	input wire logic [1:0] local_bus_clock_ratio_wdata,
	output logic sync_clock_out,
	output logic [BUS_CLOCK_OUTS-1:0] bus_clock_out_n,
	output logic system_bus_clock,
	output logic [clock_dist_pkg::SYSTEM_PLL_MULTIPLIER_WIDTH-1:0] system_pll_multiplier,
	output logic [clock_dist_pkg::CORE_PLL_SETTING_WIDTH-1:0] core_pll_setting,
	output logic memory_clock_mode,
	output logic local_bus_clock_mode,
	output logic vco_double,
	output logic memory_bus_clock_pair_p,
	output logic memory_bus_clock_pair_n,
	output logic memory_data_tick,
	output logic [2:0] local_bus_clock_outs,
	output logic [clock_dist_pkg::UNIT_COUNT-1:0] unit_clock_outs,
	output logic twowire2_clock,
	output logic [11:0] system_clock_control,
	output logic [1:0] local_bus_clock_ratio_reg,
	output logic host_ratio_error
);
	localparam int PC = clock_dist_pkg::PIN_COUNT;
	logic [PC-1:0] pin_s1_reg;
	logic [PC-1:0] pin_s2_reg;
	logic [PC-1:0] pin_s3_reg;
	logic [PC-1:0] pin_reg;
	logic primary;
	logic primary_d_reg;
	logic primary_rise;
	logic sync_d_reg;
	logic sync_rise;
	logic csb_phase_reg;
	logic [1:0] lb_cnt_reg;
	logic [1:0] lb_half;
	logic [2:0] ratio_cnt_reg;
	logic [2:0] ratio_total;
	logic ratio_valid_reg;

	// ==========================================
	// pin inputs: three stages, change taken once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
			pin_reg <= '0;
		end
		else if (ce)
		begin
			pin_s1_reg <= {input_divide_select, sync_clock_in, bus_clock_in, host_primary_clock_in};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_reg <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
		end
	end

	// host input is ignored in agent mode, where the board grounds it
	assign primary = pci_host_mode ? pin_reg[clock_dist_pkg::PIN_HOST_CLK]
		: pin_reg[clock_dist_pkg::PIN_BUS_CLK];
	assign primary_rise = primary & ~primary_d_reg;
	assign sync_rise = pin_reg[clock_dist_pkg::PIN_SYNC_IN] & ~sync_d_reg;

	// ==========================================
	// sync output and bus clock outputs
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			primary_d_reg <= 1'b0;
			sync_clock_out <= 1'b0;
			bus_clock_out_n <= '0;
		end
		else if (ce)
		begin
			primary_d_reg <= primary;
			if (!pci_host_mode)
				sync_clock_out <= 1'b0;
			else if (pin_reg[clock_dist_pkg::PIN_DIV_SEL])
				sync_clock_out <= sync_clock_out ^ primary_rise;
			else
				sync_clock_out <= primary;
			bus_clock_out_n <= output_clock_control & {BUS_CLOCK_OUTS{sync_clock_out}};
		end
	end

	// ==========================================
	// loopback ratio check; the first interval after reset has no reference
	assign ratio_total = ratio_cnt_reg + {2'h0, primary_rise};
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sync_d_reg <= 1'b0;
			ratio_cnt_reg <= 3'h0;
			ratio_valid_reg <= 1'b0;
			host_ratio_error <= 1'b0;
		end
		else if (ce)
		begin
			sync_d_reg <= pin_reg[clock_dist_pkg::PIN_SYNC_IN];
			if (!pci_host_mode)
			begin
				ratio_cnt_reg <= 3'h0;
				ratio_valid_reg <= 1'b0;
				host_ratio_error <= 1'b0;
			end
			else if (sync_rise)
			begin
				ratio_cnt_reg <= 3'h0;
				ratio_valid_reg <= 1'b1;
				if (ratio_valid_reg)
					host_ratio_error <= ratio_total !=
						(clock_dist_pkg::RATIO_UNDIVIDED + {2'h0, pin_reg[clock_dist_pkg::PIN_DIV_SEL]});
			end
			else if (ratio_cnt_reg != clock_dist_pkg::RATIO_SAT)
				ratio_cnt_reg <= ratio_total;
		end
	end

	// ==========================================
	// reset configuration word, caught while reset is held
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			system_pll_multiplier <= reset_config_word_low[clock_dist_pkg::RCW_SYSTEM_PLL_MULTIPLIER_LSB +:
				clock_dist_pkg::SYSTEM_PLL_MULTIPLIER_WIDTH];
			core_pll_setting <= reset_config_word_low[clock_dist_pkg::RCW_CORE_PLL_SETTING_LSB +:
				clock_dist_pkg::CORE_PLL_SETTING_WIDTH];
			memory_clock_mode <= reset_config_word_low[clock_dist_pkg::RCW_MEMORY_CLOCK_MODE_BIT];
			local_bus_clock_mode <= reset_config_word_low[clock_dist_pkg::RCW_LOCAL_BUS_CLOCK_MODE_BIT];
			vco_double <= reset_config_word_low[clock_dist_pkg::RCW_MEMORY_CLOCK_MODE_BIT]
				| reset_config_word_low[clock_dist_pkg::RCW_LOCAL_BUS_CLOCK_MODE_BIT];
		end
	end

	// ==========================================
	// system bus, memory and local bus clocks; clk stands for twice the bus clock
	always_comb
	begin
		case (local_bus_clock_ratio_reg)
			clock_dist_pkg::LB_DIV2: lb_half = clock_dist_pkg::LB_HP_DIV2;
			clock_dist_pkg::LB_DIV4: lb_half = clock_dist_pkg::LB_HP_DIV4;
			default: lb_half = clock_dist_pkg::LB_HP_DIV8;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			csb_phase_reg <= 1'b0;
			system_bus_clock <= 1'b0;
			twowire2_clock <= 1'b0;
			memory_bus_clock_pair_p <= 1'b0;
			memory_bus_clock_pair_n <= 1'b1;
			memory_data_tick <= 1'b0;
			lb_cnt_reg <= 2'h0;
			local_bus_clock_outs <= 3'h0;
		end
		else if (ce)
		begin
			csb_phase_reg <= ~csb_phase_reg;
			system_bus_clock <= ~system_bus_clock;
			twowire2_clock <= ~twowire2_clock;
			// pair toggles once per memory clock tick, so it runs at half that rate
			memory_data_tick <= memory_clock_mode | csb_phase_reg;
			if (memory_clock_mode | csb_phase_reg)
			begin
				memory_bus_clock_pair_p <= ~memory_bus_clock_pair_p;
				memory_bus_clock_pair_n <= memory_bus_clock_pair_p;
			end
			if (local_bus_clock_mode | csb_phase_reg)
			begin
				if (lb_cnt_reg >= lb_half)
				begin
					lb_cnt_reg <= 2'h0;
					local_bus_clock_outs <= ~local_bus_clock_outs;
				end
				else
					lb_cnt_reg <= lb_cnt_reg + 2'h1;
			end
		end
	end

	// ==========================================
	// ratio registers, writable only once out of reset
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			system_clock_control <= clock_dist_pkg::SYSTEM_CLOCK_CONTROL_RESET;
			local_bus_clock_ratio_reg <= clock_dist_pkg::LOCAL_BUS_CLOCK_RATIO_REG_RESET;
		end
		else if (ce)
		begin
			if (system_clock_control_write)
				system_clock_control <= system_clock_control_wdata;
			if (local_bus_clock_ratio_write)
				local_bus_clock_ratio_reg <= local_bus_clock_ratio_wdata;
		end
	end

	// ==========================================
	// unit clocks; divided codes on the pci/dma unit are replaced by full here
	for (genvar u = 0; u < clock_dist_pkg::UNIT_COUNT; u++)
	begin : g_unit
		unit_clock_gen #(
			.ALLOW_DIVIDE(u != clock_dist_pkg::UNIT_PCI_DMA),
			.RESET_MODE(u == clock_dist_pkg::UNIT_PCI_DMA ? clock_dist_pkg::UNIT_FULL : clock_dist_pkg::UNIT_THIRD)
		) u_gen (
			.clk(clk),
			.srst(srst),
			.ce(ce),
			.mode_in(system_clock_control[u*clock_dist_pkg::UNIT_FIELD_WIDTH +:
				clock_dist_pkg::UNIT_FIELD_WIDTH]),
			.clk_out(unit_clock_outs[u])
		);
	end
endmodule : system_clock_distribution

// >>> src/clock_dist_pkg.sv
package clock_dist_pkg;
	// ==========================================
	// reset configuration word low, field layout
	localparam int RCW_WIDTH = 32;
	localparam int RCW_SYSTEM_PLL_MULTIPLIER_LSB = 24;
	localparam int SYSTEM_PLL_MULTIPLIER_WIDTH = 4;
	localparam int RCW_CORE_PLL_SETTING_LSB = 16;
	localparam int CORE_PLL_SETTING_WIDTH = 7;
	localparam int RCW_MEMORY_CLOCK_MODE_BIT = 30;
	localparam int RCW_LOCAL_BUS_CLOCK_MODE_BIT = 31;
	// ==========================================
	// unit clock modes
	typedef enum logic [1:0] {
		UNIT_OFF = 2'h0,
		UNIT_FULL = 2'h1,
		UNIT_HALF = 2'h2,
		UNIT_THIRD = 2'h3
	} unit_mode_t;
	localparam int UNIT_FIELD_WIDTH = 2;
	localparam int UNIT_COUNT = 6;
	localparam int UNIT_PCI_DMA = 4;
	localparam logic [1:0] HP_FULL = 2'h0;
	localparam logic [1:0] HP_HALF = 2'h1;
	localparam logic [1:0] HP_THIRD = 2'h2;
	// default: every unit at third rate, pci/dma complex at full
	localparam logic [11:0] SYSTEM_CLOCK_CONTROL_RESET = 12'hDFF;
	// ==========================================
	// local bus divide
	typedef enum logic [1:0] {
		LB_DIV2 = 2'h0,
		LB_DIV4 = 2'h1,
		LB_DIV8 = 2'h2
	} lb_divide_t;
	localparam logic [1:0] LB_HP_DIV2 = 2'h0;
	localparam logic [1:0] LB_HP_DIV4 = 2'h1;
	localparam logic [1:0] LB_HP_DIV8 = 2'h3;
	localparam logic [1:0] LOCAL_BUS_CLOCK_RATIO_REG_RESET = 2'h0;
	// ==========================================
	// pin synchroniser slots
	localparam int PIN_COUNT = 4;
	localparam int PIN_HOST_CLK = 0;
	localparam int PIN_BUS_CLK = 1;
	localparam int PIN_SYNC_IN = 2;
	localparam int PIN_DIV_SEL = 3;
	localparam logic [2:0] RATIO_UNDIVIDED = 3'h1;
	localparam logic [2:0] RATIO_SAT = 3'h7;
endpackage : clock_dist_pkg

// >>> src/unit_clock_gen.sv
`timescale 1ns/1ps
module unit_clock_gen #(
	parameter bit ALLOW_DIVIDE = 1'b1,
	parameter logic [1:0] RESET_MODE = 2'h3
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [1:0] mode_in,
	output logic clk_out
);
	logic [1:0] mode_reg;
	logic [1:0] cnt_reg;
	logic [1:0] mode_next;
	logic [1:0] half_period;

	always_comb
	begin
		if (ALLOW_DIVIDE || mode_in == clock_dist_pkg::UNIT_OFF)
			mode_next = mode_in;
		else
			mode_next = clock_dist_pkg::UNIT_FULL;
		case (mode_reg)
			clock_dist_pkg::UNIT_FULL: half_period = clock_dist_pkg::HP_FULL;
			clock_dist_pkg::UNIT_HALF: half_period = clock_dist_pkg::HP_HALF;
			clock_dist_pkg::UNIT_THIRD: half_period = clock_dist_pkg::HP_THIRD;
			default: half_period = clock_dist_pkg::HP_FULL;
		endcase
	end

	// ==========================================
	// divider; new mode taken only as a low phase begins or while off, so no phase is cut short
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			mode_reg <= RESET_MODE;
			cnt_reg <= 2'h0;
			clk_out <= 1'b0;
		end
		else if (ce)
		begin
			if (mode_reg == clock_dist_pkg::UNIT_OFF)
			begin
				clk_out <= 1'b0;
				cnt_reg <= 2'h0;
				mode_reg <= mode_next;
			end
			else if (cnt_reg == half_period)
			begin
				cnt_reg <= 2'h0;
				clk_out <= ~clk_out;
				if (clk_out)
					mode_reg <= mode_next;
			end
			else
				cnt_reg <= cnt_reg + 2'h1;
		end
	end
endmodule : unit_clock_gen

// >>> tb/system_clock_distribution_props.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module system_clock_distribution_props #(
	parameter int BUS_CLOCK_OUTS = 5
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic pci_host_mode,
	input wire logic [31:0] reset_config_word_low,
	input wire logic [BUS_CLOCK_OUTS-1:0] output_clock_control,
	input wire logic system_clock_control_write,
	input wire logic [11:0] system_clock_control_wdata,
	input wire logic sync_clock_out,
	input wire logic [BUS_CLOCK_OUTS-1:0] bus_clock_out_n,
	input wire logic [3:0] system_pll_multiplier,
	input wire logic [6:0] core_pll_setting,
	input wire logic memory_clock_mode,
	input wire logic local_bus_clock_mode,
	input wire logic vco_double,
	input wire logic memory_bus_clock_pair_p,
	input wire logic memory_bus_clock_pair_n,
	input wire logic [5:0] unit_clock_outs,
	input wire logic twowire2_clock,
	input wire logic [11:0] system_clock_control
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// ==========================================
	// assertions
	a_cfg_caught: assert property ($fell(srst) |->
		system_pll_multiplier == $past(reset_config_word_low[27:24])
		&& core_pll_setting == $past(reset_config_word_low[22:16])) else $error("config not caught");
	a_vco_scale: assert property (vco_double == (memory_clock_mode | local_bus_clock_mode))
		else $error("vco scale wrong");
	a_out_gate: assert property (ce |=> bus_clock_out_n ==
		($past(output_clock_control) & {BUS_CLOCK_OUTS{$past(sync_clock_out)}})) else $error("bus out gate");
	a_agent_quiet: assert property (!pci_host_mode && $past(!pci_host_mode) && $past(ce) |-> !sync_clock_out)
		else $error("sync out in agent");
	a_pair_compl: assert property (memory_bus_clock_pair_p != memory_bus_clock_pair_n)
		else $error("pair not complementary");
	a_pair_fast: assert property (memory_clock_mode && ce |=> $changed(memory_bus_clock_pair_p))
		else $error("pair not toggling");
	a_scc_write: assert property (system_clock_control_write && ce |=>
		system_clock_control == $past(system_clock_control_wdata)) else $error("write lost");
	// off waits for the next high phase to end, so allow a few cycles
	a_unit_off: assert property ((ce && system_clock_control[1:0] == 2'h0) [*7] |-> !unit_clock_outs[0])
		else $error("unit not off");
	a_fixed_clock: assert property (ce |=> twowire2_clock != $past(twowire2_clock))
		else $error("fixed clock stalled");
	c_write: cover property (system_clock_control_write && ce);
	c_off: cover property (system_clock_control[1:0] == 2'h0 && !unit_clock_outs[0]);
	c_sync: cover property ($rose(sync_clock_out));
endmodule : system_clock_distribution_props

bind system_clock_distribution system_clock_distribution_props #(.BUS_CLOCK_OUTS(BUS_CLOCK_OUTS)) props_i (.*);

// >>> tb/board_clock_model.sv
`timescale 1ns/1ps
// ==========================================
// board clock source and sync loopback
module board_clock_model (
	input wire logic host_mode,
	input wire logic sync_out,
	output logic host_clk,
	output logic pci_clk,
	output logic sync_in
);
	// slow pin clock, edges kept off the sampling edge
	initial
	begin
		host_clk = 1'b0;
		pci_clk = 1'b0;
		#3;
		forever
		begin
			#170;
			host_clk = host_mode ? ~host_clk : 1'b0;
			pci_clk = ~pci_clk;
		end
	end
	assign sync_in = sync_out;
endmodule : board_clock_model

// >>> tb/system_clock_distribution_tb.sv
`timescale 1ns/1ps
module system_clock_distribution_tb;
	logic clk, srst, ce, pci_host_mode, host_primary_clock_in, bus_clock_in, sync_clock_in, input_divide_select;
	logic system_clock_control_write, local_bus_clock_ratio_write, sync_clock_out, system_bus_clock;
	logic memory_clock_mode, local_bus_clock_mode, vco_double, memory_bus_clock_pair_p, memory_bus_clock_pair_n;
	logic memory_data_tick, twowire2_clock, host_ratio_error;
	logic [31:0] reset_config_word_low;
	logic [4:0] output_clock_control, bus_clock_out_n;
	logic [11:0] system_clock_control_wdata, system_clock_control;
	logic [1:0] local_bus_clock_ratio_wdata, local_bus_clock_ratio_reg;
	logic [3:0] system_pll_multiplier;
	logic [6:0] core_pll_setting;
	logic [2:0] local_bus_clock_outs;
	logic [5:0] unit_clock_outs;
	logic [31:0] words [3] = '{32'h4532_0000, 32'h8A11_0000, 32'h0300_0000};
	int hp [4] = '{1, 2, 4, 4};
	int failures = 0;
	int cmp_count = 0;
	wire logic [9:0] pr = {memory_data_tick, unit_clock_outs[3], bus_clock_out_n[1:0], system_bus_clock,
		unit_clock_outs[4], unit_clock_outs[0],
		local_bus_clock_outs[0], memory_bus_clock_pair_p, sync_clock_out};
	system_clock_distribution uut (.*);
	board_clock_model board (.host_mode(pci_host_mode), .sync_out(sync_clock_out),
		.host_clk(host_primary_clock_in), .pci_clk(bus_clock_in), .sync_in(sync_clock_in));
	// ==========================================
	// tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	// rise to rise, skipping the first period while a new setting settles
	task per(input int i, input int e);
		int n, r, s;
		logic p;
		n = 0;
		r = 0;
		s = 0;
		p = pr[i];
		while (n < 200 && r < 3)
		begin
			@(negedge clk);
			n++;
			if (pr[i] === 1'b1 && p === 1'b0)
			begin
				r++;
				s = (r == 3) ? n - s : n;
			end
			p = pr[i];
		end
		chk((r == 3) ? s : 0, e);
	endtask : per
	task wr(input bit lb, input logic [11:0] d);
		@(posedge clk);
		system_clock_control_write <= !lb;
		local_bus_clock_ratio_write <= lb;
		system_clock_control_wdata <= d;
		local_bus_clock_ratio_wdata <= d[1:0];
		@(posedge clk);
		system_clock_control_write <= 1'b0;
		local_bus_clock_ratio_write <= 1'b0;
		#1;
	endtask : wr
	task rst(input logic [31:0] w);
		@(posedge clk);
		srst <= 1'b1;
		reset_config_word_low <= w;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
	endtask : rst
	task give_verdict;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// ==========================================
	// clock, watchdog, sequence
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		#1000000;
		failures++;
		give_verdict();
	end
	initial
	begin
		logic [11:0] v;
		srst = 1'b1;
		ce = 1'b1;
		pci_host_mode = 1'b1;
		input_divide_select = 1'b0;
		reset_config_word_low = 32'h0;
		output_clock_control = 5'h1F;
		system_clock_control_write = 1'b0;
		local_bus_clock_ratio_write = 1'b0;
		system_clock_control_wdata = 12'h0;
		local_bus_clock_ratio_wdata = 2'h0;
		for (int k = 0; k < 3; k++)
		begin
			rst(words[k]);
			chk({system_clock_control, local_bus_clock_ratio_reg}, {12'hDFF, 2'h0});
			chk({system_pll_multiplier, core_pll_setting}, {words[k][27:24], words[k][22:16]});
			chk(vco_double, words[k][30] | words[k][31]);
			per(1, words[k][30] ? 2 : 4);
			per(9, words[k][30] ? 0 : 2);
			for (int r = 0; r < 4; r++)
			begin
				wr(1'b1, 12'(r));
				per(2, 2 * hp[r] * (words[k][31] ? 1 : 2));
			end
			$display("config test %0d done", k);
		end
		per(3, 6);
		per(8, 6);
		per(4, 2);
		per(5, 2);
		// pci/dma field takes every code, but only off or full may show
		for (int c = 3; c >= 0; c--)
		begin
			v = {6{2'(c)}};
			wr(1'b0, v);
			chk(system_clock_control, v);
			per(3, 2 * c);
			per(4, (c != 0) ? 2 : 0);
		end
		wr(1'b0, 12'h0);
		per(4, 0);
		@(posedge clk);
		ce <= 1'b0;
		wr(1'b0, 12'h555);
		@(posedge clk);
		ce <= 1'b1;
		chk(system_clock_control, 12'h0);
		$display("unit test done");
		for (int d = 0; d < 2; d++)
		begin
			@(posedge clk);
			input_divide_select <= d[0];
			output_clock_control <= 5'h15;
			rst(32'h0);
			per(0, 17 * (d + 1));
			per(6, 17 * (d + 1));
			per(7, 0);
			chk(host_ratio_error, 1'b0);
		end
		@(posedge clk);
		pci_host_mode <= 1'b0;
		rst(32'h0);
		per(0, 0);
		$display("pin test done");
		give_verdict();
	end
endmodule : system_clock_distribution_tb
